/* pkg/serial_shift_defs.svh */
// Register indices, field positions, reset values and timing counts.
// Assumes a 32-bit bus whose byte address is four times the index.
`ifndef SERIAL_SHIFT_DEFS_SVH
`define SERIAL_SHIFT_DEFS_SVH
`define IDX_ROUTE      8'hDD
`define IDX_DATA       8'hE0
`define IDX_FRAME      8'hE1
`define IDX_MODE       8'hE2
`define IDX_STATUS     8'hF0
`define IDX_MASK       8'hF1
`define MODE_RESET     8'h00
`define FRAME_RESET    8'h00
`define DATA_RESET     8'h00
`define FLAG_BIT       7
`define ROUTE_BIT      0
`define ST_FRAME_BIT   0
`define ST_STOP_BIT    1
`define CORE_DIV       12'd13
`define RATE_MAX_CODE  3'h7
`define RATE_MAX_SHIFT 4'h8
`endif

/* pkg/serial_shift_pkg.sv */
// Types shared by the serial shift block.
// Assumes the field layout of serial_shift_defs.svh.
package serial_shift_pkg;
    typedef struct packed {
        logic       run;
        logic       irq_en;
        logic       clock_phase_select;
        logic       clk_src;
        logic       in_sel;
        logic       start_sel;
        logic       filt_off;
        logic       clock_polarity_select;
    } mode_t;
    typedef struct packed {
        logic       flag;
        logic [3:0] len;
        logic [2:0] rate;
    } frame_t;
    typedef enum logic {IDLE, RUN} shift_state_t;
endpackage

/* rtl/serial_shift_frame_control.sv */
// Serial shift interface: frame length, bit-rate divider, shift register,
// interrupt flag and output-pin routing, behind an Avalon-MM slave.
// Assumes pins are asynchronous to sys_clk and are synchronised here.
`timescale 1ns/1ps
`include "serial_shift_defs.svh"
module serial_shift_frame_control
    import serial_shift_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // Avalon-MM slave
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Serial pins
    input  wire logic        sin_pin,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe_n,
    output logic             sout,
    output logic             sout_oe_n,
    // General-purpose port side of the serial-out pin
    input  wire logic        gpio_out,
    input  wire logic        gpio_oe_n,
    // Interrupt
    output logic             irq
);

    // Shift period in sys_clk cycles for a rate code
    function automatic logic [11:0] period_of(input logic [2:0] code);
        logic [3:0] sh;
        sh = (code == `RATE_MAX_CODE) ? `RATE_MAX_SHIFT : {1'b0, code};
        period_of = `CORE_DIV << sh;
    endfunction

    mode_t        mode_reg;
    frame_t       frame_reg;
    shift_state_t state_reg;
    logic [7:0]   data_reg;
    logic         route_reg;
    logic [1:0]   stat_reg;
    logic [1:0]   mask_reg;
    logic [3:0]   bit_cnt_reg;
    logic [11:0]  div_cnt_reg;
    logic         out_bit_reg;
    logic         sin_meta;
    logic         sin_s;
    logic         sck_meta;
    logic         sck_s;
    logic         sck_d;
    logic         wait_reg;
    logic [3:0]   trail_cnt;

    // Bus decode; answer one cycle after the request appears
    wire [7:0]  idx      = avs_address[9:2];
    wire        req      = avs_read | avs_write;
    wire        acc      = req & ~avs_waitrequest;
    wire        wr_acc   = acc & avs_write;
    wire        rd_acc   = acc & avs_read;
    wire [7:0]  wdata    = avs_writedata[7:0];
    wire        wr_mode  = wr_acc & (idx == `IDX_MODE);
    wire        wr_frame = wr_acc & (idx == `IDX_FRAME);
    wire        wr_data  = wr_acc & (idx == `IDX_DATA);
    wire        wr_route = wr_acc & (idx == `IDX_ROUTE);
    wire        wr_mask  = wr_acc & (idx == `IDX_MASK);
    wire        rd_stat  = rd_acc & (idx == `IDX_STATUS);
    wire [7:0]  rd_mux   = (idx == `IDX_DATA)   ? data_reg :
                           (idx == `IDX_FRAME)  ? frame_reg :
                           (idx == `IDX_MODE)   ? mode_reg :
                           (idx == `IDX_STATUS) ? {6'h00, stat_reg} :
                           (idx == `IDX_MASK)   ? {6'h00, mask_reg} : 8'h00;

    // Edge generation, master from divider, slave from the pin
    wire        running  = (state_reg == RUN);
    wire        master   = mode_reg.clk_src;
    wire [11:0] period   = period_of(frame_reg.rate);
    wire [11:0] half     = period >> 1;
    wire        lead_m   = running & (div_cnt_reg == half - 12'd1);
    wire        trail_m  = running & (div_cnt_reg == period - 12'd1);
    wire        sck_edge = sck_s ^ sck_d;
    wire        lead_s   = running & sck_edge & (sck_s != mode_reg.clock_polarity_select);
    wire        trail_s  = running & sck_edge & (sck_s == mode_reg.clock_polarity_select);
    wire        lead     = master ? lead_m : lead_s;
    wire        trail    = master ? trail_m : trail_s;
    wire        samp     = mode_reg.clock_phase_select ? trail : lead;
    wire        chg      = mode_reg.clock_phase_select ? lead : trail;
    wire        in_bit   = mode_reg.in_sel & sin_s;
    wire        start    = ~running & mode_reg.run & (~mode_reg.start_sel | sin_s);

    // Frame end and early stop; both raise the done flag
    wire        frame_end = trail & (bit_cnt_reg == 4'h1);
    wire        stop_evt  = wr_mode & mode_reg.run & ~wdata[7];
    wire        done_evt  = frame_end | stop_evt;
    wire [1:0]  stat_set  = {stop_evt, frame_end};
    // Clear only what the read returned; an event in the read's first cycle survives
    wire [1:0]  stat_next = (rd_stat ? stat_reg & ~avs_readdata[1:0] : stat_reg) | stat_set;
    wire        flag_next = done_evt | (frame_reg.flag & ~(wr_frame & ~wdata[`FLAG_BIT]));

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sin_meta <= 1'b0;
            sin_s    <= 1'b0;
            sck_meta <= 1'b0;
            sck_s    <= 1'b0;
            sck_d    <= 1'b0;
        end else begin
            sin_meta <= sin_pin;
            sin_s    <= sin_meta;
            sck_meta <= sck_in;
            sck_s    <= sck_meta;
            sck_d    <= sck_s;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_reg     <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            wait_reg     <= ~(req & wait_reg);
            avs_readdata <= {24'h00_0000, rd_mux};
        end
    end
    assign avs_waitrequest = wait_reg;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg  <= `MODE_RESET;
            route_reg <= 1'b0;
            mask_reg  <= 2'b00;
            stat_reg  <= 2'b00;
        end else begin
            if (wr_mode)
                mode_reg <= wdata;
            if (frame_end)
                mode_reg.run <= 1'b0;
            if (wr_route)
                route_reg <= wdata[`ROUTE_BIT];
            if (wr_mask)
                mask_reg <= wdata[1:0];
            // Set wins over the read that clears
            stat_reg <= stat_next;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_reg <= `FRAME_RESET;
        end else begin
            if (wr_frame & ~mode_reg.run)
                {frame_reg.len, frame_reg.rate} <= wdata[6:0];
            frame_reg.flag <= flag_next;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg   <= IDLE;
            bit_cnt_reg <= 4'h0;
            div_cnt_reg <= 12'h000;
        end else begin
            case (state_reg)
                IDLE: begin
                    div_cnt_reg <= 12'h000;
                    if (start) begin
                        state_reg   <= RUN;
                        bit_cnt_reg <= frame_reg.len;
                    end
                end
                RUN: begin
                    div_cnt_reg <= trail_m ? 12'h000 : div_cnt_reg + 12'd1;
                    if (trail)
                        bit_cnt_reg <= bit_cnt_reg - 4'h1;
                    if (frame_end | stop_evt | ~mode_reg.run)
                        state_reg <= IDLE;
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    // Extra leading bits fall off the top of the register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_reg    <= `DATA_RESET;
            out_bit_reg <= 1'b0;
        end else begin
            if (wr_data & ~mode_reg.run)
                data_reg <= wdata;
            else if (samp)
                data_reg <= {data_reg[6:0], in_bit};
            if (start & ~mode_reg.clock_phase_select)
                out_bit_reg <= data_reg[7];
            else if (chg)
                out_bit_reg <= data_reg[7];
        end
    end

    // Pin outputs, all registered
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_out   <= 1'b0;
            sck_oe_n  <= 1'b1;
            sout      <= 1'b0;
            sout_oe_n <= 1'b1;
            irq       <= 1'b0;
        end else begin
            sck_oe_n <= ~master;
            if (~running)
                sck_out <= mode_reg.clock_polarity_select;
            else if (lead_m)
                sck_out <= ~mode_reg.clock_polarity_select;
            else if (trail_m)
                sck_out <= mode_reg.clock_polarity_select;
            sout      <= route_reg ? out_bit_reg : gpio_out;
            sout_oe_n <= route_reg ? 1'b0 : gpio_oe_n;
            irq       <= mode_reg.irq_en & |(stat_reg & mask_reg);
        end
    end

    // Helper: trailing edges seen in the current frame
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            trail_cnt <= 4'h0;
        else if (start)
            trail_cnt <= 4'h0;
        else if (trail)
            trail_cnt <= trail_cnt + 4'h1;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_stop;
        stop_evt;
    endsequence
    sequence s_stopped;
        !mode_reg.run && frame_reg.flag && state_reg == IDLE;
    endsequence

    property p_flag_set;
        frame_end |=> frame_reg.flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set at frame end");

    property p_no_sw_set;
        $rose(frame_reg.flag) |-> $past(done_evt);
    endproperty
    a_no_sw_set: assert property (p_no_sw_set) else $error("flag rose without event");

    property p_cfg_locked;
        wr_frame && mode_reg.run |=> $stable({frame_reg.len, frame_reg.rate});
    endproperty
    a_cfg_locked: assert property (p_cfg_locked) else $error("config written while run");

    property p_data_locked;
        wr_data && mode_reg.run && !samp |=> $stable(data_reg);
    endproperty
    a_data_locked: assert property (p_data_locked) else $error("data written while run");

    property p_frame_len;
        frame_end |-> trail_cnt + 4'h1 == frame_reg.len;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length mismatch");

    property p_irq_gate;
        !mode_reg.irq_en |=> !irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");

    property p_stop;
        s_stop |=> s_stopped;
    endproperty
    a_stop: assert property (p_stop) else $error("early stop not handled");

    property p_route;
        route_reg |=> sout == $past(out_bit_reg) && !sout_oe_n;
    endproperty
    a_route: assert property (p_route) else $error("serial out not routed");

    property p_idle_clk;
        master && !running ##1 master && !running |-> sck_out == $past(mode_reg.clock_polarity_select);
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("clock not idle");

    property p_zero_in;
        samp && !mode_reg.in_sel && !wr_data |=> data_reg[0] == 1'b0;
    endproperty
    a_zero_in: assert property (p_zero_in) else $error("input not zero");

    property p_msb;
        chg && !start |=> out_bit_reg == $past(data_reg[7]);
    endproperty
    a_msb: assert property (p_msb) else $error("msb not shifted first");

    property p_end_run;
        frame_end |=> !mode_reg.run && state_reg == IDLE;
    endproperty
    a_end_run: assert property (p_end_run) else $error("run left set");

    property p_stop_stat;
        stop_evt |=> stat_reg[`ST_STOP_BIT];
    endproperty
    a_stop_stat: assert property (p_stop_stat) else $error("stop not flagged");

    property p_irq_on;
        mode_reg.irq_en && (stat_reg & mask_reg) != 2'b00 |=> irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq not raised");

    property p_in_sel;
        samp && mode_reg.in_sel && !wr_data |=> data_reg[0] == $past(sin_s);
    endproperty
    a_in_sel: assert property (p_in_sel) else $error("serial in not taken");

    property p_gpio;
        !route_reg |=> sout == $past(gpio_out) && sout_oe_n == $past(gpio_oe_n);
    endproperty
    a_gpio: assert property (p_gpio) else $error("pin not on port logic");

    property p_flag_clr;
        wr_frame && !wdata[`FLAG_BIT] && !done_evt |=> !frame_reg.flag;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

endmodule

/* tb/serial_peer_model.sv */
// Behavioural far-side serial peripheral, MSB first, mode set by the bench.
// Assumes it is reloaded only while the shift clock idles.
`timescale 1ns/1ps
module serial_peer_model (
    // Serial lines
    input  wire logic        sck,
    input  wire logic        sdi,
    output logic             sdo,
    // Bench control
    input  wire logic        clock_polarity_select,
    input  wire logic        clock_phase_select,
    input  wire logic        reload,
    input  wire logic [15:0] tx_word,
    output logic      [15:0] rx_word
);
    logic [15:0] tx_reg = 16'h0000;
    logic        first_reg = 1'h1;
    logic        seen = 1'h0;
    assign sdo = tx_reg[15];
    always @(sck or reload) begin
        if (reload) begin
            seen = sck;
            tx_reg    <= tx_word;
            rx_word   <= 16'h0000;
            first_reg <= 1'h1;
        end else if (sck !== seen) begin
            seen = sck;
            if ((sck != clock_polarity_select) ^ clock_phase_select) begin
                rx_word <= {rx_word[14:0], sdi};
            end else if (clock_phase_select && first_reg) begin
                // Shifted phase: bit 15 already stands, first edge only arms
                first_reg <= 1'h0;
            end else begin
                tx_reg <= {tx_reg[14:0], 1'h0};
            end
        end
    end
endmodule

/* tb/tb_top.sv */
// Bench for the serial shift block: every rate code, lengths 1, 2, 4, 8, 12 and 15, all
// clock modes, slave clocking, interrupt, early stop and pin routing.
// Assumes the block's package, defines header and the peer model.
`timescale 1ns/1ps
`include "serial_shift_defs.svh"
module tb_top
    import serial_shift_pkg::*;
;
    typedef struct packed {
        logic [7:0]  data;
        logic [3:0]  len;
        logic [2:0]  rate;
        logic        clock_polarity_select;
        logic        clock_phase_select;
        logic        in_sel;
        logic        src;
        logic [15:0] ptx;
    } row_t;
    row_t        rows [10] = '{
        '{8'hA5, 4'h8, 3'h0, 1'h0, 1'h0, 1'h1, 1'h1, 16'h3C00},
        '{8'h5A, 4'h8, 3'h1, 1'h1, 1'h0, 1'h1, 1'h1, 16'hC300},
        '{8'h81, 4'h4, 3'h2, 1'h0, 1'h1, 1'h1, 1'h1, 16'h9000},
        '{8'h7E, 4'h8, 3'h3, 1'h1, 1'h1, 1'h0, 1'h1, 16'hFFFF},
        '{8'hC3, 4'hC, 3'h4, 1'h0, 1'h0, 1'h1, 1'h1, 16'hABCD},
        '{8'h3C, 4'h1, 3'h5, 1'h1, 1'h1, 1'h1, 1'h1, 16'h8000},
        '{8'h96, 4'h2, 3'h6, 1'h0, 1'h0, 1'h1, 1'h1, 16'h4000},
        '{8'h69, 4'h2, 3'h7, 1'h1, 1'h0, 1'h1, 1'h1, 16'hC000},
        '{8'hE7, 4'hF, 3'h0, 1'h0, 1'h1, 1'h1, 1'h1, 16'h1234},
        '{8'h3C, 4'h8, 3'h0, 1'h0, 1'h0, 1'h1, 1'h0, 16'hC5C5}};
    logic [7:0]  ids [7] = '{`IDX_ROUTE, `IDX_DATA, `IDX_FRAME, `IDX_MODE,
                             `IDX_STATUS, `IDX_MASK, 8'h10};
    logic        sys_clk = 1'h0, arst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
    logic [9:0]  avs_address = 10'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic        avs_waitrequest, sin_pin, sck_out, sck_oe_n, sout, sout_oe_n, irq;
    logic        sck_ext = 1'h0, gpio_out = 1'h0, gpio_oe_n = 1'h1, src_sel = 1'h1;
    logic        p_clock_polarity_select = 1'h0, p_clock_phase_select = 1'h0, p_load = 1'h0, sck_prev = 1'h0;
    logic [15:0] p_tx = 16'h0000, p_rx;
    wire         sck_line = src_sel ? sck_out : sck_ext;
    int          error_cnt = 0, samples_checked = 0;
    int          cyc = 0, t_lead = 0, lead_period = 0, lead_cnt = 0;

    serial_shift_frame_control i_dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sin_pin(sin_pin), .sck_in(sck_ext), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
        .sout(sout), .sout_oe_n(sout_oe_n), .gpio_out(gpio_out),
        .gpio_oe_n(gpio_oe_n), .irq(irq));
    serial_peer_model i_peer (
        .sck(sck_line), .sdi(sout), .sdo(sin_pin), .clock_polarity_select(p_clock_polarity_select), .clock_phase_select(p_clock_phase_select),
        .reload(p_load), .tx_word(p_tx), .rx_word(p_rx));

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // Leading edges of the shift clock: count and spacing, plus the hang limit
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        sck_prev <= sck_line;
        if (sck_line !== sck_prev && sck_line !== p_clock_polarity_select) begin
            lead_period <= cyc - t_lead;
            t_lead <= cyc;
            lead_cnt <= lead_cnt + 1;
        end
        if (cyc == 60000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge sys_clk);
        avs_address   <= {idx, 2'h0};
        avs_writedata <= {24'h0, wd};
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'h0);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read  <= 1'h0;
    endtask
    // Data register and far-side capture after n MSB-first shifts
    function automatic logic [23:0] shift_model(input row_t r);
        logic [7:0]  d;
        logic [15:0] o;
        d = r.data;
        o = 16'h0000;
        for (int i = 0; i < r.len; i++) begin
            o = {o[14:0], d[7]};
            d = {d[6:0], r.in_sel & r.ptx[15 - i]};
        end
        return {d, o};
    endfunction
    task automatic run_frame(input row_t r);
        mode_t m;
        int    base;
        m = '{1'h0, 1'h1, r.clock_phase_select, r.src, r.in_sel, 1'h0, 1'h0, r.clock_polarity_select};
        bus(1'h1, `IDX_DATA, r.data);
        bus(1'h1, `IDX_FRAME, {1'h0, r.len, r.rate});
        bus(1'h1, `IDX_MODE, m);
        repeat (4) @(posedge sys_clk);
        src_sel <= r.src;
        p_clock_polarity_select  <= r.clock_polarity_select;
        p_clock_phase_select  <= r.clock_phase_select;
        p_tx    <= r.ptx;
        p_load  <= 1'h1;
        @(posedge sys_clk);
        p_load  <= 1'h0;
        base = lead_cnt;
        m.run = 1'h1;
        bus(1'h1, `IDX_MODE, m);
        chk("sck direction", sck_oe_n, !r.src);
        if (!r.src) begin
            repeat (2 * r.len) begin
                repeat (8) @(posedge sys_clk);
                sck_ext <= !sck_ext;
            end
            repeat (8) @(posedge sys_clk);
        end
        do begin
            bus(1'h0, `IDX_MODE, 8'h00);
        end while (rd[7] !== 1'h0);
        chk("lead edges", lead_cnt - base, r.len);
        if (r.src && r.len > 1) begin
            chk("sck period", lead_period, 13 * ((r.rate == 3'h7) ? 256 : (1 << r.rate)));
        end
        if (r.src) chk("sck idle", sck_out, r.clock_polarity_select);
        bus(1'h0, `IDX_DATA, 8'h00);
        chk("rx data", rd, shift_model(r) >> 16);
        chk("peer rx", p_rx, shift_model(r) & 24'h00FFFF);
        bus(1'h0, `IDX_FRAME, 8'h00);
        chk("done flag", rd, {1'h1, r.len, r.rate});
        chk("irq raised", irq, 1'h1);
        bus(1'h0, `IDX_STATUS, 8'h00);
        chk("status", rd, 32'h1);
        bus(1'h1, `IDX_FRAME, {1'h0, r.len, r.rate});
        chk("irq cleared", irq, 1'h0);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        chk("outputs in reset", {sck_oe_n, sout_oe_n, irq, avs_waitrequest}, 4'hD);
        arst_n <= 1'h1;
        foreach (ids[i]) begin
            bus(1'h0, ids[i], 8'h00);
            chk("reset value", rd, 32'h0);
        end
        bus(1'h1, `IDX_ROUTE, 8'h01);
        bus(1'h1, `IDX_MASK, 8'h01);
        bus(1'h1, 8'h10, 8'hFF);
        bus(1'h0, 8'h10, 8'h00);
        chk("unmapped", rd, 32'h0);
        bus(1'h0, `IDX_ROUTE, 8'h00);
        chk("route write-only", rd, 32'h0);
        $display("test registers done");
        foreach (rows[i]) begin
            run_frame(rows[i]);
            $display("test row %0d done", i);
        end
        // Early stop at the slowest rate, locked writes in mid-frame
        bus(1'h1, `IDX_FRAME, 8'h47);
        bus(1'h1, `IDX_DATA, 8'h5A);
        bus(1'h1, `IDX_MODE, 8'hD0);
        bus(1'h1, `IDX_DATA, 8'h00);
        bus(1'h1, `IDX_FRAME, 8'h09);
        bus(1'h0, `IDX_DATA, 8'h00);
        chk("locked data", rd, 32'h5A);
        bus(1'h0, `IDX_FRAME, 8'h00);
        chk("locked frame", rd, 32'h47);
        bus(1'h1, `IDX_MODE, 8'h50);
        repeat (4) @(posedge sys_clk);
        bus(1'h0, `IDX_MODE, 8'h00);
        chk("stopped", rd, 32'h50);
        chk("sck after stop", sck_out, 1'h0);
        chk("masked irq", irq, 1'h0);
        bus(1'h0, `IDX_STATUS, 8'h00);
        chk("stop status", rd[1], 1'h1);
        bus(1'h1, `IDX_FRAME, 8'h00);
        bus(1'h1, `IDX_FRAME, 8'h87);
        bus(1'h0, `IDX_FRAME, 8'h00);
        chk("flag not settable", rd, 32'h07);
        $display("test early stop done");
        // Start waits for serial-in high when start select is on
        p_tx   <= 16'h0000;
        p_load <= 1'h1;
        bus(1'h1, `IDX_FRAME, 8'h08);
        p_load <= 1'h0;
        bus(1'h1, `IDX_MODE, 8'h94);
        repeat (40) @(posedge sys_clk);
        bus(1'h0, `IDX_MODE, 8'h00);
        chk("start held", rd, 32'h94);
        p_tx   <= 16'h8000;
        p_load <= 1'h1;
        @(posedge sys_clk);
        p_load <= 1'h0;
        repeat (40) @(posedge sys_clk);
        bus(1'h0, `IDX_MODE, 8'h00);
        chk("start on sin", rd, 32'h14);
        $display("test start select done");
        bus(1'h1, `IDX_ROUTE, 8'h00);
        gpio_out  <= 1'h1;
        gpio_oe_n <= 1'h0;
        repeat (3) @(posedge sys_clk);
        chk("gpio pin", {sout, sout_oe_n}, 2'h2);
        bus(1'h1, `IDX_ROUTE, 8'h01);
        gpio_oe_n <= 1'h1;
        repeat (3) @(posedge sys_clk);
        chk("routed pin", sout_oe_n, 1'h0);
        $display("test routing done");
        report_and_stop();
    end
endmodule
